// ### design/slp_map.svh
`ifndef SLP_MAP_SVH
`define SLP_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SLP_OFF_KEEP_LDO    8'h41
`define SLP_OFF_KEEP_RES    8'h42
`define SLP_OFF_LDO_OFF     8'h43
`define SLP_OFF_CONV_OFF    8'h44
`define SLP_OFF_PIN1_LDO    8'h45
`define SLP_OFF_PIN1_CONV   8'h46
`define SLP_OFF_PIN2_LDO    8'h47

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SLP_BIT_THERM       7
`define SLP_BIT_CLKOUT      6
`define SLP_BIT_RTC         5
`define SLP_BIT_FASTCLK     4
`define SLP_BIT_CORE2       2
`define SLP_BIT_CORE1       1
`define SLP_BIT_IO          0
`define SLP_BIT_DEFVOLT     7
`define SLP_BIT_FET         3

// Writable bits, the rest read zero; SLP_MASK_ASSIGN picks the pin-assignable bits
`define SLP_MASK_KEEP_RES   8'hf7
`define SLP_MASK_CONV_OFF   8'h9f
`define SLP_MASK_PIN1_CONV  8'h1f
`define SLP_MASK_ASSIGN     8'h0f

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define SLP_RST_CFG         8'h00
`define SLP_ST_OFF0         2'h0
`define SLP_ST_ACTIVE       2'h1
`define SLP_ST_OFF2         2'h2
`define SLP_ST_LOWPWR       2'h3
`define SLP_LDO_OFF         2'h0
`define SLP_LDO_LOW         2'h1
`define SLP_LDO_FULL        2'h2
`define SLP_CONV_OFF        2'h0
`define SLP_CONV_PFM        2'h1
`define SLP_CONV_PWM        2'h2

`endif

// ### design/slp_pkg.sv
package slp_pkg;

  // Register bank contents
  typedef struct packed {
    logic [7:0] keep_ldo;
    logic [7:0] keep_res;
    logic [7:0] ldo_off;
    logic [7:0] conv_off;
    logic [7:0] pin1_ldo;
    logic [7:0] pin1_conv;
    logic [7:0] pin2_ldo;
    logic [7:0] rdata;
    logic       rvalid;
  } slp_bank_t;

  // Decision logic outputs, all registered
  typedef struct packed {
    logic [15:0] ldo_mode;
    logic        rtc_full;
    logic        therm_en;
    logic        fastclk_en;
    logic        clkout;
    logic [1:0]  io_mode;
    logic [1:0]  core1_mode;
    logic [1:0]  core2_mode;
    logic [7:0]  core1_vsel;
    logic [7:0]  core2_vsel;
    logic [7:0]  fet_vsel;
    logic        fet_on;
    logic        sleep_d;
    logic        wake_default;
    logic        wake_saved;
    logic        sr_disable;
  } slp_core_t;

endpackage

// ### design/slp_cfg_if.sv
`timescale 1ns/1ps
interface slp_cfg_if;
  logic [7:0] keep_ldo;
  logic [7:0] keep_res;
  logic [7:0] ldo_off;
  logic [7:0] conv_off;
  logic [7:0] pin1_ldo;
  logic [7:0] pin1_conv;
  logic [7:0] pin2_ldo;
  modport bank (output keep_ldo, keep_res, ldo_off, conv_off,
                output pin1_ldo, pin1_conv, pin2_ldo);
  modport core (input keep_ldo, keep_res, ldo_off, conv_off,
                input pin1_ldo, pin1_conv, pin2_ldo);
endinterface

// ### design/slp_reg_bank.sv
`timescale 1ns/1ps
`include "slp_map.svh"
module slp_reg_bank
  import slp_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  // Register access
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  output logic            reg_rvalid_out,
  // Configuration to decision logic
  slp_cfg_if.bank         cfg
);

  slp_bank_t st_ff;
  slp_bank_t nxt_st;

  // ----------------------------------------------------------------
  // Address decode, shared by write and read paths
  // ----------------------------------------------------------------
  function automatic logic [6:0] sel_of(input logic [7:0] a);
    logic [6:0] s;
    s = 7'h00;
    case (a)
      `SLP_OFF_KEEP_LDO:  s = 7'h01;
      `SLP_OFF_KEEP_RES:  s = 7'h02;
      `SLP_OFF_LDO_OFF:   s = 7'h04;
      `SLP_OFF_CONV_OFF:  s = 7'h08;
      `SLP_OFF_PIN1_LDO:  s = 7'h10;
      `SLP_OFF_PIN1_CONV: s = 7'h20;
      `SLP_OFF_PIN2_LDO:  s = 7'h40;
      default:            s = 7'h00;
    endcase
    return s;
  endfunction

  // Writes store only implemented bits; reserved bits stay zero
  always_comb begin
    logic [6:0] ws;
    logic [6:0] rs;
    ws = sel_of(reg_addr_in) & {7{reg_wr_in}};
    rs = sel_of(reg_addr_in);
    nxt_st = st_ff;
    if (ws[0]) nxt_st.keep_ldo = reg_wdata_in;
    if (ws[1]) nxt_st.keep_res = reg_wdata_in & `SLP_MASK_KEEP_RES;
    if (ws[2]) nxt_st.ldo_off = reg_wdata_in;
    if (ws[3]) nxt_st.conv_off = reg_wdata_in & `SLP_MASK_CONV_OFF;
    if (ws[4]) nxt_st.pin1_ldo = reg_wdata_in;
    if (ws[5]) nxt_st.pin1_conv = reg_wdata_in & `SLP_MASK_PIN1_CONV;
    if (ws[6]) nxt_st.pin2_ldo = reg_wdata_in;
    // Unmapped offsets read as zero, one cycle after the strobe
    nxt_st.rvalid = reg_rd_in;
    nxt_st.rdata = 8'h00;
    if (reg_rd_in) begin
      nxt_st.rdata = ({8{rs[0]}} & st_ff.keep_ldo)
                   | ({8{rs[1]}} & st_ff.keep_res)
                   | ({8{rs[2]}} & st_ff.ldo_off)
                   | ({8{rs[3]}} & st_ff.conv_off)
                   | ({8{rs[4]}} & st_ff.pin1_ldo)
                   | ({8{rs[5]}} & st_ff.pin1_conv)
                   | ({8{rs[6]}} & st_ff.pin2_ldo);
    end
  end

  // All fields clear on reset
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata_out  = st_ff.rdata;
  assign reg_rvalid_out = st_ff.rvalid;
  assign cfg.keep_ldo   = st_ff.keep_ldo;
  assign cfg.keep_res   = st_ff.keep_res;
  assign cfg.ldo_off    = st_ff.ldo_off;
  assign cfg.conv_off   = st_ff.conv_off;
  assign cfg.pin1_ldo   = st_ff.pin1_ldo;
  assign cfg.pin1_conv  = st_ff.pin1_conv;
  assign cfg.pin2_ldo   = st_ff.pin2_ldo;

endmodule

// ### design/slp_sleep_ctrl.sv
`timescale 1ns/1ps
`include "slp_map.svh"
module slp_sleep_ctrl
  import slp_pkg::*;
#(
  parameter int VSEL_W = 8
)
(
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              srst_in,
  // Register access from the control serial bus
  input  wire logic [7:0]        reg_addr_in,
  input  wire logic [7:0]        reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [7:0]        reg_rdata_out,
  output logic                   reg_rvalid_out,
  // Device state and enable pins
  input  wire logic              sleep_state_in,
  input  wire logic              first_enable_pin_in,
  input  wire logic              second_enable_pin_in,
  input  wire logic              slow_clock_in,
  // Per-resource supply state fields and modes
  input  wire logic [15:0]       ldo_supply_state_in,
  input  wire logic [1:0]        io_supply_state_in,
  input  wire logic [1:0]        core1_supply_state_in,
  input  wire logic [1:0]        core2_supply_state_in,
  input  wire logic [1:0]        fet_supply_state_in,
  input  wire logic [2:0]        conv_pulse_frequency_mode_in,
  // Voltage codes; a code of zero programs the supply off only while it is assigned to the first enable pin
  input  wire logic [VSEL_W-1:0] core1_operating_voltage_in,
  input  wire logic [VSEL_W-1:0] core1_scaled_voltage_in,
  input  wire logic [VSEL_W-1:0] core2_operating_voltage_in,
  input  wire logic [VSEL_W-1:0] core2_scaled_voltage_in,
  input  wire logic [VSEL_W-1:0] fet_ctrl_operating_voltage_in,
  input  wire logic [VSEL_W-1:0] fet_ctrl_scaled_voltage_in,
  // Resource controls
  output logic      [15:0]       ldo_mode_out,
  output logic                   rtc_ldo_full_load_out,
  output logic                   thermal_monitor_en_out,
  output logic                   fast_clock_en_out,
  output logic                   slow_clock_output_out,
  output logic      [1:0]        io_conv_mode_out,
  output logic      [1:0]        core1_conv_mode_out,
  output logic      [1:0]        core2_conv_mode_out,
  output logic      [VSEL_W-1:0] core1_voltage_out,
  output logic      [VSEL_W-1:0] core2_voltage_out,
  output logic                   fet_controller_on_out,
  output logic      [VSEL_W-1:0] fet_ctrl_voltage_out,
  // Wake and pin muxing
  output logic                   wake_use_default_voltage_out,
  output logic                   wake_use_saved_voltage_out,
  output logic                   sr_interface_disable_out
);

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  slp_cfg_if cfg_bus ();

  slp_reg_bank u_bank (
    .clk_in         (clk_in),
    .srst_in        (srst_in),
    .reg_addr_in    (reg_addr_in),
    .reg_wdata_in   (reg_wdata_in),
    .reg_wr_in      (reg_wr_in),
    .reg_rd_in      (reg_rd_in),
    .reg_rdata_out  (reg_rdata_out),
    .reg_rvalid_out (reg_rvalid_out),
    .cfg            (cfg_bus.bank)
  );

  slp_core_t st_ff;
  slp_core_t nxt_st;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Both off codes of the supply state field count as off
  function automatic logic is_off(input logic [1:0] s);
    return (s == `SLP_ST_OFF0) || (s == `SLP_ST_OFF2);
  endfunction

  // Converter mode for I/O and core converters, shared by all three
  function automatic logic [1:0] conv_decide(
    input logic [1:0] sst,
    input logic       assigned,
    input logic       pin,
    input logic       keep,
    input logic       setoff,
    input logic       sleep,
    input logic       pfm_now,
    input logic       is_core,
    input logic       op_zero,
    input logic       sr_zero
  );
    logic [1:0] run;
    logic [1:0] m;
    run = pfm_now ? `SLP_CONV_PFM : `SLP_CONV_PWM;
    m = `SLP_CONV_OFF;
    if (is_off(sst)) begin
      m = `SLP_CONV_OFF;
    end else if (assigned && is_core) begin
      if (pin) begin
        m = op_zero ? `SLP_CONV_OFF : run;
      end else if (sr_zero) begin
        m = `SLP_CONV_OFF;
      end else begin
        m = keep ? `SLP_CONV_PFM : run;
      end
    end else if (assigned) begin
      if (pin) begin
        m = run;
      end else begin
        m = keep ? `SLP_CONV_PFM : `SLP_CONV_OFF;
      end
    end else if (sleep) begin
      if (setoff && !keep) begin
        m = `SLP_CONV_OFF;
      end else if (keep) begin
        m = run;
      end else begin
        m = `SLP_CONV_PFM;
      end
      if (sst == `SLP_ST_LOWPWR && m != `SLP_CONV_OFF) begin
        m = `SLP_CONV_PFM;
      end
    end else begin
      // Outside sleep the supply state field and PFM mode alone decide
      m = (sst == `SLP_ST_LOWPWR) ? `SLP_CONV_PFM : run;
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // Per-LDO decision
  // ----------------------------------------------------------------
  // Bit i of every per-LDO register belongs to the same regulator,
  // so one loop serves all eight.
  logic [15:0] ldo_mode_c;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_ldo
      logic [1:0] sst;
      logic       keep;
      logic       a1;
      logic       a2;
      logic       pin_on;
      logic [1:0] m;
      assign sst  = ldo_supply_state_in[2*gi +: 2];
      assign keep = cfg_bus.keep_ldo[gi];
      assign a1   = cfg_bus.pin1_ldo[gi];
      assign a2   = cfg_bus.pin2_ldo[gi];
      // With both pins assigned, either pin high turns the LDO on
      assign pin_on = (a1 & first_enable_pin_in)
                    | (a2 & second_enable_pin_in);
      always_comb begin
        m = `SLP_LDO_OFF;
        if (is_off(sst)) begin
          m = `SLP_LDO_OFF;
        end else if (a1 || a2) begin
          if (pin_on) begin
            m = `SLP_LDO_FULL;
          end else begin
            m = keep ? `SLP_LDO_LOW : `SLP_LDO_OFF;
          end
        end else if (sleep_state_in) begin
          if (cfg_bus.ldo_off[gi] && !keep) begin
            m = `SLP_LDO_OFF;
          end else if (keep && sst != `SLP_ST_LOWPWR) begin
            m = `SLP_LDO_FULL;
          end else begin
            m = `SLP_LDO_LOW;
          end
        end else begin
          // Pins ignored; state field and device state decide
          m = (sst == `SLP_ST_LOWPWR) ? `SLP_LDO_LOW
                                      : `SLP_LDO_FULL;
        end
      end
      assign ldo_mode_c[2*gi +: 2] = m;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic sleep_gate;
  logic c1_a;
  logic c2_a;
  logic io_a;
  logic fet_a;

  assign sleep_gate = sleep_state_in;
  assign io_a  = cfg_bus.pin1_conv[`SLP_BIT_IO];
  assign c1_a  = cfg_bus.pin1_conv[`SLP_BIT_CORE1];
  assign c2_a  = cfg_bus.pin1_conv[`SLP_BIT_CORE2];
  assign fet_a = cfg_bus.pin1_conv[`SLP_BIT_FET];

  always_comb begin
    nxt_st = st_ff;
    nxt_st.ldo_mode = ldo_mode_c;

    // Always-on services gated only by sleep and their keep bit
    nxt_st.therm_en = !sleep_gate
                    || cfg_bus.keep_res[`SLP_BIT_THERM];
    nxt_st.fastclk_en = !sleep_gate
                      || cfg_bus.keep_res[`SLP_BIT_FASTCLK];
    nxt_st.rtc_full = !sleep_gate
                    || cfg_bus.keep_res[`SLP_BIT_RTC];
    // Re-timed copy of the slow clock; costs one cycle of skew
    nxt_st.clkout = slow_clock_in
                  && (!sleep_gate
                      || cfg_bus.keep_res[`SLP_BIT_CLKOUT]);

    // Converters
    nxt_st.io_mode = conv_decide(io_supply_state_in, io_a,
                       first_enable_pin_in,
                       cfg_bus.keep_res[`SLP_BIT_IO],
                       cfg_bus.conv_off[`SLP_BIT_IO],
                       sleep_gate, conv_pulse_frequency_mode_in[0],
                       1'b0, 1'b0, 1'b0);
    nxt_st.core1_mode = conv_decide(core1_supply_state_in, c1_a,
                          first_enable_pin_in,
                          cfg_bus.keep_res[`SLP_BIT_CORE1],
                          cfg_bus.conv_off[`SLP_BIT_CORE1],
                          sleep_gate, conv_pulse_frequency_mode_in[1],
                          1'b1, core1_operating_voltage_in == '0,
                          core1_scaled_voltage_in == '0);
    nxt_st.core2_mode = conv_decide(core2_supply_state_in, c2_a,
                          first_enable_pin_in,
                          cfg_bus.keep_res[`SLP_BIT_CORE2],
                          cfg_bus.conv_off[`SLP_BIT_CORE2],
                          sleep_gate, conv_pulse_frequency_mode_in[2],
                          1'b1, core2_operating_voltage_in == '0,
                          core2_scaled_voltage_in == '0);

    // Voltage code follows the pin only when assigned
    if (c1_a && !first_enable_pin_in) begin
      nxt_st.core1_vsel = core1_scaled_voltage_in;
    end else begin
      nxt_st.core1_vsel = core1_operating_voltage_in;
    end
    if (c2_a && !first_enable_pin_in) begin
      nxt_st.core2_vsel = core2_scaled_voltage_in;
    end else begin
      nxt_st.core2_vsel = core2_operating_voltage_in;
    end

    // FET controller has no keep bit, so sleep-off acts alone
    if (is_off(fet_supply_state_in)) begin
      nxt_st.fet_on = 1'b0;
      nxt_st.fet_vsel = fet_ctrl_operating_voltage_in;
    end else if (fet_a) begin
      nxt_st.fet_vsel = first_enable_pin_in
                      ? fet_ctrl_operating_voltage_in
                      : fet_ctrl_scaled_voltage_in;
      nxt_st.fet_on = first_enable_pin_in
                    ? (fet_ctrl_operating_voltage_in != '0)
                    : (fet_ctrl_scaled_voltage_in != '0);
    end else begin
      nxt_st.fet_vsel = fet_ctrl_operating_voltage_in;
      nxt_st.fet_on = !(sleep_gate
                        && cfg_bus.conv_off[`SLP_BIT_FET]);
    end

    // Sleep exit pulse picks the wake voltage source
    nxt_st.sleep_d = sleep_gate;
    nxt_st.wake_default = st_ff.sleep_d && !sleep_gate
                        && cfg_bus.conv_off[`SLP_BIT_DEFVOLT];
    nxt_st.wake_saved = st_ff.sleep_d && !sleep_gate
                      && !cfg_bus.conv_off[`SLP_BIT_DEFVOLT];

    // Enable pins leave the voltage-scaling port once any is assigned
    nxt_st.sr_disable = (|cfg_bus.pin1_ldo)
                      || (|cfg_bus.pin2_ldo)
                      || (|(cfg_bus.pin1_conv
                            & `SLP_MASK_ASSIGN));
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset leaves every supply off until the first decision settles
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign ldo_mode_out                 = st_ff.ldo_mode;
  assign rtc_ldo_full_load_out        = st_ff.rtc_full;
  assign thermal_monitor_en_out       = st_ff.therm_en;
  assign fast_clock_en_out            = st_ff.fastclk_en;
  assign slow_clock_output_out        = st_ff.clkout;
  assign io_conv_mode_out             = st_ff.io_mode;
  assign core1_conv_mode_out          = st_ff.core1_mode;
  assign core2_conv_mode_out          = st_ff.core2_mode;
  assign core1_voltage_out            = st_ff.core1_vsel;
  assign core2_voltage_out            = st_ff.core2_vsel;
  assign fet_controller_on_out        = st_ff.fet_on;
  assign fet_ctrl_voltage_out         = st_ff.fet_vsel;
  assign wake_use_default_voltage_out = st_ff.wake_default;
  assign wake_use_saved_voltage_out   = st_ff.wake_saved;
  assign sr_interface_disable_out     = st_ff.sr_disable;

endmodule

// ### tb/slp_sleep_ctrl_assertions.sv
`timescale 1ns/1ps
`include "slp_map.svh"
module slp_sleep_ctrl_chk #(
  parameter int VSEL_W = 8
) (
  // Clock, reset, writes
  input wire logic              clk_in,
  input wire logic              srst_in,
  input wire logic [7:0]        reg_addr_in,
  input wire logic [7:0]        reg_wdata_in,
  input wire logic              reg_wr_in,
  // State, pins, codes
  input wire logic              sleep_state_in,
  input wire logic              first_enable_pin_in,
  input wire logic              slow_clock_in,
  input wire logic [VSEL_W-1:0] fet_ctrl_operating_voltage_in,
  input wire logic [VSEL_W-1:0] fet_ctrl_scaled_voltage_in,
  // Watched controls
  input wire logic              thermal_monitor_en_out,
  input wire logic              slow_clock_output_out,
  input wire logic              rtc_ldo_full_load_out,
  input wire logic              fast_clock_en_out,
  input wire logic [VSEL_W-1:0] fet_ctrl_voltage_out,
  input wire logic              wake_use_default_voltage_out,
  input wire logic              wake_use_saved_voltage_out,
  input wire logic              sr_interface_disable_out
);
  logic [7:0] k_ff, c_ff, a1_ff, a2_ff;
  logic [3:0] a1c_ff;
  logic       rel_ff, rel2_ff;
  // ----------------------------------------------------------------
  // Configuration shadows
  // ----------------------------------------------------------------
  // Shadows predict decisions from ports
  always_ff @(posedge clk_in) begin
    rel_ff  <= !srst_in;
    rel2_ff <= rel_ff;
    if (srst_in) begin
      {k_ff, c_ff, a1_ff, a2_ff, a1c_ff} <= 36'h0;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `SLP_OFF_KEEP_RES:  k_ff   <= reg_wdata_in;
        `SLP_OFF_CONV_OFF:  c_ff   <= reg_wdata_in;
        `SLP_OFF_PIN1_LDO:  a1_ff  <= reg_wdata_in;
        `SLP_OFF_PIN2_LDO:  a2_ff  <= reg_wdata_in;
        `SLP_OFF_PIN1_CONV: a1c_ff <= reg_wdata_in[3:0];
        default: ;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // Guards skip the first edge after reset
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  therm_keep_a: assert property (rel_ff && $past(sleep_state_in)
    |-> thermal_monitor_en_out == $past(k_ff[7]))
    else $error("thermal enable");
  clk_gate_a: assert property (rel_ff && $past(sleep_state_in)
    |-> slow_clock_output_out == ($past(k_ff[6]) & $past(slow_clock_in)))
    else $error("slow clock out");
  rtc_keep_a: assert property (rel_ff && $past(sleep_state_in)
    |-> rtc_ldo_full_load_out == $past(k_ff[5]))
    else $error("rtc full load");
  fast_clk_a: assert property (rel_ff && $past(sleep_state_in)
    |-> fast_clock_en_out == $past(k_ff[4]))
    else $error("fast clock");
  sr_disable_a: assert property (rel_ff |-> sr_interface_disable_out ==
    ($past(a1_ff) != 8'h0 || $past(a2_ff) != 8'h0 || $past(a1c_ff) != 4'h0))
    else $error("sr disable");
  wake_default_a: assert property (rel_ff && rel2_ff
    |-> wake_use_default_voltage_out == (!$past(sleep_state_in)
      && $past(sleep_state_in, 2) && $past(c_ff[7])))
    else $error("default pulse");
  wake_saved_a: assert property (rel_ff && rel2_ff
    |-> wake_use_saved_voltage_out == (!$past(sleep_state_in)
      && $past(sleep_state_in, 2) && !$past(c_ff[7])))
    else $error("saved pulse");
  fet_volt_a: assert property (rel_ff && $past(a1c_ff[3])
    |-> fet_ctrl_voltage_out == ($past(first_enable_pin_in)
      ? $past(fet_ctrl_operating_voltage_in)
      : $past(fet_ctrl_scaled_voltage_in)))
    else $error("fet code");
  cover property (wake_use_default_voltage_out);
  cover property (sr_interface_disable_out);
  cover property (sleep_state_in && thermal_monitor_en_out);
endmodule

bind slp_sleep_ctrl slp_sleep_ctrl_chk #(.VSEL_W(VSEL_W)) chk_u (.*);

// ### tb/slp_host_pins.sv
`timescale 1ns/1ps
module slp_host_pins (
  // Clock and requests
  input  wire logic clk_in,
  input  wire logic pin1_req_in,
  input  wire logic pin2_req_in,
  // Enable pins toward the block
  output logic      first_enable_pin_out = 1'b0,
  output logic      second_enable_pin_out = 1'b0
);
  // Host moves its pins just after an edge and holds them as levels
  always @(posedge clk_in) begin
    first_enable_pin_out  <= pin1_req_in;
    second_enable_pin_out <= pin2_req_in;
  end
endmodule

// ### tb/slp_sleep_ctrl_tb.sv
`timescale 1ns/1ps
`include "slp_map.svh"
module slp_sleep_ctrl_tb;
  logic        clk_in, srst_in, wr, rd, slp, p1r, p2r, pin1, pin2, slow;
  logic [7:0]  addr, wd, rdata, c1op, c1sr, fop, fsr, c1v, c2v, fv;
  logic [15:0] lss, ldo_m;
  logic [1:0]  ss, io_m, c1_m, c2_m;
  logic        rv, rtc, therm, fast, sco, fon, wdef, wsav, srd;
  int          num_errors, n_compared, cyc;
  // ----------------------------------------------------------------
  // Block, host model and clock
  // ----------------------------------------------------------------
  slp_sleep_ctrl dut_u (.clk_in(clk_in), .srst_in(srst_in),
    .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .reg_rvalid_out(rv), .sleep_state_in(slp),
    .first_enable_pin_in(pin1), .second_enable_pin_in(pin2),
    .slow_clock_in(slow), .ldo_supply_state_in(lss),
    .io_supply_state_in(ss), .core1_supply_state_in(ss),
    .core2_supply_state_in(ss), .fet_supply_state_in(ss),
    .conv_pulse_frequency_mode_in(3'h0),
    .core1_operating_voltage_in(c1op), .core1_scaled_voltage_in(c1sr),
    .core2_operating_voltage_in(c1op), .core2_scaled_voltage_in(c1sr),
    .fet_ctrl_operating_voltage_in(fop), .fet_ctrl_scaled_voltage_in(fsr),
    .ldo_mode_out(ldo_m), .rtc_ldo_full_load_out(rtc),
    .thermal_monitor_en_out(therm), .fast_clock_en_out(fast),
    .slow_clock_output_out(sco), .io_conv_mode_out(io_m),
    .core1_conv_mode_out(c1_m), .core2_conv_mode_out(c2_m),
    .core1_voltage_out(c1v), .core2_voltage_out(c2v),
    .fet_controller_on_out(fon), .fet_ctrl_voltage_out(fv),
    .wake_use_default_voltage_out(wdef), .wake_use_saved_voltage_out(wsav),
    .sr_interface_disable_out(srd));
  slp_host_pins host_u (.clk_in(clk_in), .pin1_req_in(p1r),
    .pin2_req_in(p2r), .first_enable_pin_out(pin1),
    .second_enable_pin_out(pin2));
  // Free-running clock
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // Hang guard, ample margin
  always @(posedge clk_in) begin
    cyc++;
    if (cyc >= 3000) begin
      num_errors++;
      summarize();
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk_in);
    wr = 1'b0;
  endtask
  // Read data stands one cycle; judge at once
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_in);
    addr = a;
    rd = 1'b1;
    @(negedge clk_in);
    rd = 1'b0;
    cmp({15'h0, rv}, 16'h1);
    cmp({8'h0, rdata}, {8'h0, exp});
  endtask
  // Host model adds a cycle; allow four
  task automatic settle();
    repeat (4) @(negedge clk_in);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] a;
    for (a = 8'h41; a <= 8'h47; a++) rd_chk(a, 8'h00);
    rd_chk(8'h50, 8'h00);
    wr_reg(`SLP_OFF_KEEP_RES, 8'hff);
    rd_chk(`SLP_OFF_KEEP_RES, 8'hf7);
    wr_reg(`SLP_OFF_CONV_OFF, 8'hff);
    rd_chk(`SLP_OFF_CONV_OFF, 8'h9f);
    wr_reg(`SLP_OFF_PIN1_CONV, 8'hff);
    rd_chk(`SLP_OFF_PIN1_CONV, 8'h1f);
    wr_reg(`SLP_OFF_PIN1_CONV, 8'h10);
    rd_chk(`SLP_OFF_PIN1_CONV, 8'h10);
    wr_reg(`SLP_OFF_CONV_OFF, 8'h00);
  endtask
  task automatic t_keep_res();
    slp = 1'b1;
    wr_reg(`SLP_OFF_KEEP_RES, 8'hf7);
    settle();
    cmp({therm, sco, rtc, fast}, 16'hf);
    cmp({io_m, c1_m, c2_m}, 16'h2a);
    wr_reg(`SLP_OFF_KEEP_RES, 8'h00);
    settle();
    cmp({therm, sco, rtc, fast}, 16'h0);
    cmp({io_m, c1_m, c2_m}, 16'h15);
    wr_reg(`SLP_OFF_CONV_OFF, 8'h04);
    settle();
    cmp({io_m, c1_m, c2_m}, 16'h14);
    wr_reg(`SLP_OFF_CONV_OFF, 8'h00);
  endtask
  task automatic t_ldo_sleep();
    wr_reg(`SLP_OFF_KEEP_LDO, 8'h80);
    wr_reg(`SLP_OFF_LDO_OFF, 8'hc1);
    settle();
    cmp(ldo_m, 16'h8554);
    slp = 1'b0;
    settle();
    cmp(ldo_m, 16'haaaa);
    wr_reg(`SLP_OFF_KEEP_LDO, 8'h00);
  endtask
  task automatic t_pin_ldo();
    wr_reg(`SLP_OFF_PIN1_LDO, 8'h01);
    settle();
    cmp(ldo_m, 16'haaa8);
    cmp({15'h0, srd}, 16'h1);
    p1r = 1'b1;
    settle();
    cmp(ldo_m, 16'haaaa);
    wr_reg(`SLP_OFF_KEEP_LDO, 8'h01);
    p1r = 1'b0;
    settle();
    cmp(ldo_m, 16'haaa9);
    wr_reg(`SLP_OFF_PIN1_LDO, 8'h00);
    wr_reg(`SLP_OFF_PIN2_LDO, 8'h02);
    wr_reg(`SLP_OFF_KEEP_LDO, 8'h00);
    settle();
    cmp(ldo_m, 16'haaa2);
    wr_reg(`SLP_OFF_PIN2_LDO, 8'h00);
    settle();
    cmp({15'h0, srd}, 16'h0);
  endtask
  task automatic t_pin_conv();
    wr_reg(`SLP_OFF_PIN1_CONV, 8'h0b);
    p1r = 1'b1;
    settle();
    cmp({c1v, fv}, 16'h3355);
    cmp({fon, io_m, c1_m}, 16'h1a);
    p1r = 1'b0;
    settle();
    cmp({c1v, fv}, 16'h2244);
    cmp({8'h0, c2v}, 16'h33);
    cmp({io_m, c1_m}, 16'h2);
    wr_reg(`SLP_OFF_KEEP_RES, 8'h03);
    settle();
    cmp({io_m, c1_m}, 16'h5);
    c1sr = 8'h00;
    settle();
    cmp({io_m, c1_m}, 16'h4);
    c1sr = 8'h22;
    wr_reg(`SLP_OFF_PIN1_CONV, 8'h00);
    wr_reg(`SLP_OFF_KEEP_RES, 8'h00);
  endtask
  task automatic t_wake(input logic [7:0] cfg, input logic [15:0] exp);
    wr_reg(`SLP_OFF_CONV_OFF, cfg);
    slp = 1'b1;
    settle();
    slp = 1'b0;
    @(negedge clk_in);
    cmp({wdef, wsav}, exp);
    @(negedge clk_in);
    cmp({wdef, wsav}, 16'h0);
  endtask
  task automatic summarize();
    if (num_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    {wr, rd, slp, p1r, p2r, addr, wd} = 21'h0;
    {num_errors, n_compared, cyc} = 96'h0;
    {c1op, c1sr, fop, fsr} = 32'h33225544;
    {lss, ss, slow} = {16'h5555, 2'h1, 1'b1};
    srst_in = 1'b1;
    repeat (6) @(negedge clk_in);
    srst_in = 1'b0;
    t_regs();
    t_keep_res();
    t_ldo_sleep();
    t_pin_ldo();
    t_pin_conv();
    t_wake(8'h80, 16'h2);
    t_wake(8'h00, 16'h1);
    summarize();
  end
endmodule
